// >>> hdl/vfb_regs.sv
// register bank of field buffer base addresses for two video channels
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module vfb_regs #(
    parameter int unsigned CHANNELS = vfb_pkg::NUM_CH
) (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire vfb_pkg::vfb_bus_t           bus,
    output logic [vfb_pkg::DATA_W-1:0]       rdata,
    output vfb_pkg::vfb_dma_t [CHANNELS-1:0] dma
);
    import vfb_pkg::*;

    // the map has room for exactly two channel windows below MAP_END
    generate
        if (CHANNELS != NUM_CH) begin : g_bad_channels
            $error("vfb_regs supports exactly two channels");
        end
    endgenerate

    typedef struct packed {
        vfb_ch_t [CHANNELS-1:0] ch;
        logic [DATA_W-1:0]      rdata;
    } vfb_state_t;

    localparam vfb_ch_t CH_RST = '{
        top_luma:   RST_BASE,
        bot_luma:   RST_BASE,
        top_chroma: RST_BASE,
        mode:       RST_MODE
    };

    localparam vfb_state_t S_RST = '{
        ch:    {CHANNELS{CH_RST}},
        rdata: '0
    };

    vfb_state_t s_q;
    vfb_state_t s_d;

    // offset of a register inside its channel window
    function automatic logic [7:0] reg_ofs(input logic [7:0] a);
        reg_ofs = a & (CH_STRIDE - 8'h01);
    endfunction : reg_ofs

    // first byte address of the window of channel c
    function automatic logic [7:0] ch_base(input int unsigned c);
        ch_base = 8'(c) * CH_STRIDE;
    endfunction : ch_base

    // true when the address falls in the window of channel c
    function automatic logic hit_ch(input logic [7:0] a, input int unsigned c);
        hit_ch = (a / CH_STRIDE) == 8'(c);
    endfunction : hit_ch

    // read mux of one channel; unused offsets read as zero
    function automatic logic [DATA_W-1:0] ch_read(input vfb_ch_t r, input logic [7:0] ofs);
        unique case (ofs)
            OFS_TOP_LUMA: ch_read = r.top_luma;
            OFS_BOT_LUMA: ch_read = r.bot_luma;
            OFS_TOP_CHR:  ch_read = r.top_chroma;
            OFS_MODE:     ch_read = {{(DATA_W-MODE_W){1'b0}}, r.mode};
            default:      ch_read = '0;
        endcase
    endfunction : ch_read

    // one channel after a write; base values are kept exactly as written, no alignment fix; mode keeps only its low MODE_W bits
    function automatic vfb_ch_t ch_write(input vfb_ch_t r, input logic [7:0] ofs,
                                         input logic [DATA_W-1:0] d);
        ch_write = r;
        unique case (ofs)
            OFS_TOP_LUMA: ch_write.top_luma   = d;
            OFS_BOT_LUMA: ch_write.bot_luma   = d;
            OFS_TOP_CHR:  ch_write.top_chroma = d;
            OFS_MODE:     ch_write.mode       = d[MODE_W-1:0];
            default: ;
        endcase
    endfunction : ch_write

    always_comb begin
        s_d       = s_q;
        s_d.rdata = '0;
        for (int unsigned c = 0; c < CHANNELS; c++) begin
            if (bus.wr && hit_ch(bus.addr, c)) begin
                s_d.ch[c] = ch_write(s_q.ch[c], reg_ofs(bus.addr), bus.wdata);
            end
            if (bus.rd && hit_ch(bus.addr, c)) begin
                s_d.rdata = ch_read(s_q.ch[c], reg_ofs(bus.addr));
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;

    // base addresses go to the address generator as the first active sample
    generate
        for (genvar c = 0; c < CHANNELS; c++) begin : g_dma
            logic yc;
            assign yc = s_q.ch[c].mode[MODE_YC_BIT];
            assign dma[c].top_base    = s_q.ch[c].top_luma;
            assign dma[c].bot_base    = s_q.ch[c].bot_luma;
            assign dma[c].chroma_base = s_q.ch[c].top_chroma;
            // ch1 bottom luma only in Y/C mux, ch0 top chroma likewise
            assign dma[c].bot_valid    = (c == 1) ? yc : 1'b1;
            assign dma[c].chroma_valid = (c == 0) ? yc : 1'b1;
        end
    endgenerate

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // bus level checks
    wr_stores_a: assert property (
        bus.wr && reg_ofs(bus.addr) == OFS_TOP_LUMA && bus.addr < MAP_END
        |=> dma[$past(bus.addr[4])].top_base == $past(bus.wdata))
        else $error("top luma not stored");

    bot_stores_a: assert property (
        bus.wr && bus.addr == OFS_BOT_LUMA
        |=> dma[0].bot_base == $past(bus.wdata))
        else $error("bottom luma not stored");

    chr_stores_a: assert property (
        bus.wr && bus.addr == (CH_STRIDE + OFS_TOP_CHR)
        |=> dma[1].chroma_base == $past(bus.wdata))
        else $error("chroma not stored");

    rd_data_a: assert property (
        bus.rd && bus.addr == OFS_TOP_LUMA && !bus.wr
        |=> rdata == $past(dma[0].top_base))
        else $error("read data wrong");

    hold_val_a: assert property (
        !bus.wr
        |=> $stable(dma[0].top_base) && $stable(dma[1].bot_base))
        else $error("base changed without write");

    raw_top_a: assert property (
        bus.wr && bus.addr == CH_STRIDE
        |=> dma[1].top_base == $past(bus.wdata))
        else $error("raw top base wrong");

    raw_bot_a: assert property (
        bus.wr && bus.addr == (CH_STRIDE + OFS_BOT_LUMA)
        |=> dma[1].bot_base == $past(bus.wdata))
        else $error("raw bottom base wrong");

    ch1_bot_a: assert property (
        dma[1].bot_valid == s_q.ch[1].mode[MODE_YC_BIT] && dma[0].bot_valid
        )
        else $error("ch1 bottom valid wrong");

    ch0_chr_a: assert property (
        bus.wr && bus.addr == OFS_MODE
        |=> dma[0].chroma_valid == $past(bus.wdata[0]))
        else $error("ch0 chroma valid wrong");

    unmapped_a: assert property (
        bus.rd && bus.addr >= MAP_END
        |=> rdata == '0)
        else $error("unmapped read not zero");

    rd_idle_a: assert property (
        !bus.rd
        |=> rdata == '0)
        else $error("read data outside read cycle");

    unmapped_wr_a: assert property (
        bus.wr && bus.addr >= MAP_END
        |=> $stable(dma))
        else $error("unmapped write changed a base");

    // per channel checks
    generate
        for (genvar c = 0; c < CHANNELS; c++) begin : g_chk
            localparam logic [7:0] BASE = ch_base(c);

            top_wr_a: assert property (
                bus.wr && bus.addr == BASE + OFS_TOP_LUMA
                |=> dma[c].top_base == $past(bus.wdata))
                else $error("top luma base not taken");

            bot_wr_a: assert property (
                bus.wr && bus.addr == BASE + OFS_BOT_LUMA
                |=> dma[c].bot_base == $past(bus.wdata))
                else $error("bottom luma base not taken");

            chr_wr_a: assert property (
                bus.wr && bus.addr == BASE + OFS_TOP_CHR
                |=> dma[c].chroma_base == $past(bus.wdata))
                else $error("top chroma base not taken");

            top_rd_a: assert property (
                bus.rd && bus.addr == BASE + OFS_TOP_LUMA
                |=> rdata == $past(dma[c].top_base))
                else $error("top luma readback wrong");

            bot_rd_a: assert property (
                bus.rd && bus.addr == BASE + OFS_BOT_LUMA
                |=> rdata == $past(dma[c].bot_base))
                else $error("bottom luma readback wrong");

            chr_rd_a: assert property (
                bus.rd && bus.addr == BASE + OFS_TOP_CHR
                |=> rdata == $past(dma[c].chroma_base))
                else $error("top chroma readback wrong");

            mode_rd_a: assert property (
                bus.rd && bus.addr == BASE + OFS_MODE
                |=> rdata == {{(DATA_W-MODE_W){1'b0}}, $past(s_q.ch[c].mode)})
                else $error("mode readback wrong");

            mode_wr_a: assert property (
                bus.wr && bus.addr == BASE + OFS_MODE
                |=> s_q.ch[c].mode == $past(bus.wdata[MODE_W-1:0]))
                else $error("mode not taken");

            top_keep_a: assert property (
                !(bus.wr && bus.addr == BASE + OFS_TOP_LUMA)
                |=> $stable(dma[c].top_base))
                else $error("top luma base changed unasked");

            bot_keep_a: assert property (
                !(bus.wr && bus.addr == BASE + OFS_BOT_LUMA)
                |=> $stable(dma[c].bot_base))
                else $error("bottom luma base changed unasked");

            chr_keep_a: assert property (
                !(bus.wr && bus.addr == BASE + OFS_TOP_CHR)
                |=> $stable(dma[c].chroma_base))
                else $error("top chroma base changed unasked");

            rd_keep_a: assert property (
                bus.rd
                |=> $stable(dma[c]))
                else $error("read changed a base");

            other_keep_a: assert property (
                bus.wr && !hit_ch(bus.addr, c)
                |=> $stable(dma[c]))
                else $error("write to other window changed a base");

            yc_flag_a: assert property (
                bus.wr && bus.addr == BASE + OFS_MODE
                |=> ((c == 1) ? dma[c].bot_valid : dma[c].chroma_valid) == $past(bus.wdata[MODE_YC_BIT]))
                else $error("Y/C gated valid wrong");

            valid_keep_a: assert property (
                !(bus.wr && bus.addr == BASE + OFS_MODE)
                |=> $stable(dma[c].bot_valid) && $stable(dma[c].chroma_valid))
                else $error("valid flag changed unasked");

            full_flag_a: assert property (
                ((c == 0) ? dma[c].bot_valid : dma[c].chroma_valid) == 1'b1
                )
                else $error("ungated valid low");

            raw_base_a: assert property (
                s_q.ch[c].mode[MODE_RAW_BIT]
                |-> dma[c].top_base == s_q.ch[c].top_luma && dma[c].bot_base == s_q.ch[c].bot_luma)
                else $error("raw capture base wrong");
        end
    endgenerate

    // main scenarios
    wr_then_rd_c: cover property (
        bus.wr ##1 bus.rd);

    yc_on_c: cover property (
        dma[0].chroma_valid && dma[1].bot_valid);

    back_rd_c: cover property (
        bus.rd ##1 bus.rd);

    raw_mode_c: cover property (
        bus.wr && reg_ofs(bus.addr) == OFS_MODE && bus.wdata[MODE_RAW_BIT]);

    odd_base_c: cover property (
        bus.wr && reg_ofs(bus.addr) == OFS_TOP_LUMA && bus.wdata[2:0] != 3'h0);
endmodule : vfb_regs
`default_nettype wire

// >>> include/vfb_pkg.sv
// package of constants and types for the video field buffer base register bank
`default_nettype none
package vfb_pkg;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned NUM_CH       = 2;
    // register index per channel: byte address = ch * CH_STRIDE + reg * 4
    localparam logic [7:0]  CH_STRIDE    = 8'h10;
    localparam logic [7:0]  OFS_TOP_LUMA = 8'h00;
    localparam logic [7:0]  OFS_BOT_LUMA = 8'h04;
    localparam logic [7:0]  OFS_TOP_CHR  = 8'h08;
    localparam logic [7:0]  OFS_MODE     = 8'h0c;
    // first address past the last channel window
    localparam logic [7:0]  MAP_END      = 8'h20;
    localparam int unsigned MODE_W       = 2;
    localparam logic [31:0] RST_BASE     = 32'h0000_0000;
    // mode register field positions
    localparam int unsigned MODE_YC_BIT  = 0;
    localparam int unsigned MODE_RAW_BIT = 1;
    localparam logic [1:0]  RST_MODE     = 2'h0;

    typedef struct packed {
        logic [31:0] top_luma;
        logic [31:0] bot_luma;
        logic [31:0] top_chroma;
        logic [1:0]  mode;
    } vfb_ch_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } vfb_bus_t;

    // per channel base addresses handed to the address generator
    typedef struct packed {
        logic [31:0] top_base;
        logic [31:0] bot_base;
        logic [31:0] chroma_base;
        logic        chroma_valid;
        logic        bot_valid;
    } vfb_dma_t;
endpackage : vfb_pkg
`default_nettype wire

// >>> tb/vfb_dma_model.sv
// address generator model: first sample address of each field
`timescale 1ns/1ps
`default_nettype none
module vfb_dma_model (
    input  wire logic             clk,
    input  wire vfb_pkg::vfb_dma_t dma,
    input  wire logic             bot,
    output logic [31:0]           luma,
    output logic [31:0]           chr
);
    import vfb_pkg::*;
    always_ff @(posedge clk) begin
        luma <= bot ? (dma.bot_valid ? dma.bot_base : 32'h0) : dma.top_base;
        chr  <= dma.chroma_valid ? dma.chroma_base : 32'h0;
    end
endmodule : vfb_dma_model
`default_nettype wire

// >>> tb/video_field_buffer_base_regs_tb.sv
// self-checking bench for the field buffer base register bank
`timescale 1ns/1ps
`default_nettype none
module video_field_buffer_base_regs_tb;
    import vfb_pkg::*;
    logic           clk = 1'b0;
    logic           resetn = 1'b0;
    logic           bot = 1'b0;
    vfb_bus_t       bus = '0;
    logic [31:0]    rdata;
    vfb_dma_t [1:0] dma;
    logic [31:0]    l0, l1, c0, c1;
    int             error_cnt = 0;
    int             samples_checked = 0;
    vfb_regs i_dut (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata), .dma(dma));
    vfb_dma_model i_m0 (.clk(clk), .dma(dma[0]), .bot(bot), .luma(l0), .chr(c0));
    vfb_dma_model i_m1 (.clk(clk), .dma(dma[1]), .bot(bot), .luma(l1), .chr(c1));
    initial forever #12.5 clk = ~clk;
    function automatic logic [31:0] pat(input int a);
        return 32'h8765_4321 + a;
    endfunction : pat
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input int a, input logic [31:0] d);
        bus.addr <= a[7:0];
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input int a, input logic [31:0] e);
        bus.addr <= a[7:0];
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
        @(posedge clk);
        @(negedge clk);
        chk(rdata, 32'h0);
        @(posedge clk);
    endtask : rd
    // field select, then the first sample addresses of both channels
    task automatic dchk(input logic f, input logic [31:0] el0, ec0, el1, ec1);
        bot <= f;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(l0, el0);
        chk(c0, ec0);
        chk(l1, el1);
        chk(c1, ec1);
        @(posedge clk);
    endtask : dchk
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 32; a += 4) rd(a, 32'h0);
        // odd values: misaligned bases must be kept as written
        for (int a = 0; a < 32; a += 4) if (a % 16 != 12) wr(a, pat(a));
        for (int a = 0; a < 32; a += 4) rd(a, (a % 16 == 12) ? 32'h0 : pat(a));
        dchk(1'b0, pat(0), 32'h0, pat(16), pat(24));
        dchk(1'b1, pat(4), 32'h0, 32'h0, pat(24));
        wr(12, 32'h3);
        wr(28, 32'h1);
        rd(12, 32'h3);
        dchk(1'b1, pat(4), pat(8), pat(20), pat(24));
        wr(16, 32'h0000_0100);
        wr(20, 32'h0000_0008);
        rd(16, 32'h0000_0100);
        rd(20, 32'h0000_0008);
        wr(32, 32'hffff_ffff);
        rd(32, 32'h0);
        rd(0, pat(0));
        test_done();
    end
endmodule : video_field_buffer_base_regs_tb
`default_nettype wire
